// ### core/bcg_top.sv
// Purpose: Board glue: control latch, printer port, serial side lines, decode, priority.
// Assumes: Processor I/O and memory strobes are one-cycle pulses synchronous to sys_clk.
// Notes:   All outputs leave from flip-flops; reads answer one clock after the strobe.
// Operation
// - Control latch is eight bits; seven drive floppy selects, side, density, clock.
// - One control bit enables or disables the boot ROM.
// - Reset clears every control output to zero, selecting the boot ROM.
// - Alternate channel A baud tick is the master clock divided by 104.
// - The alternate tick gives channel A rates 19200 and 38400 besides 9600.
// - Fast or slow channel A baud clock follows channel A terminal ready.
// - Request outputs drive outgoing handshakes; incoming handshakes feed clear inputs.
// - Channel B ring input senses printer busy.
// - Channel B carrier input carries optional floppy ready.
// - Channel A carrier and ring inputs serve as optional interrupt sources.
// - Printer data latch drives eight lines with the last written byte.
// - Printer strobe flip-flop is set and cleared by separate writes.
// - RAM cycles have no wait state; each ROM cycle has exactly one.
// - Non-maskable interrupt stays inactive; only maskable requests reach the CPU.
// - Daisy chain: timer 0..3 first, serial A next, serial B last.
// - Jumpers route floppy and SCSI interrupts to timer clock inputs 2, 3.
// - Input port returns the eight configuration jumpers.
// - A write to port 00h updates all eight control outputs at once.
// - Control bit 7 selects fast floppy clock when one, normal when zero.
// - Control bit 6 at zero maps ROM into lower 32K; one restores RAM.
// - Control bits 3..0 each select one floppy drive when set.
`timescale 1ns/1ps
`default_nettype none
`include "bcg_defs.svh"

module bcg_top (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire bcg_pkg::bcg_byte_t io_addr,
   input  wire bcg_pkg::bcg_byte_t io_wdata,
   input  wire logic             io_wr,
   input  wire logic             io_rd,
   output var  bcg_pkg::bcg_byte_t io_rdata,
   output logic                  io_rdata_valid,
   input  wire logic             mem_req,
   input  wire logic             mem_a15,
   output logic                  mem_ready,
   output logic                  rom_select,
   output logic                  ram_select,
   output logic                  drive_select_one,
   output logic                  drive_select_two,
   output logic                  drive_select_three,
   output logic                  drive_select_four,
   output logic                  disk_side_select,
   output logic                  density_select_n,
   output logic                  floppy_clock_fast_select,
   output logic                  boot_rom_disable,
   output var  bcg_pkg::bcg_byte_t printer_data,
   output logic                  printer_strobe,
   output logic                  alt_baud_tick,
   input  wire logic             serial_a_terminal_ready_out,
   output logic                  baud_fast_select,
   input  wire logic             serial_a_request_out,
   input  wire logic             serial_b_request_out,
   output logic                  serial_a_handshake_out,
   output logic                  serial_b_handshake_out,
   input  wire logic             serial_a_handshake_in,
   input  wire logic             serial_b_handshake_in,
   output logic                  serial_a_clear_in,
   output logic                  serial_b_clear_in,
   input  wire logic             printer_busy,
   output logic                  serial_b_ring_in,
   input  wire logic             floppy_ready,
   output logic                  serial_b_carrier_in,
   input  wire logic             aux_carrier_src,
   input  wire logic             aux_ring_src,
   input  wire logic             jumper_aux_irq_en,
   output logic                  serial_a_carrier_in,
   output logic                  serial_a_ring_in,
   input  wire logic             jumper_ctc2_floppy,
   input  wire logic             jumper_ctc3_scsi,
   input  wire logic             timer_clk_src_2,
   input  wire logic             timer_clk_src_3,
   input  wire logic             floppy_irq,
   input  wire logic             scsi_irq,
   output logic                  timer_trigger_2,
   output logic                  timer_trigger_3,
   input  wire bcg_pkg::bcg_byte_t id_jumpers,
   input  wire logic [5:0]       int_req,
   output logic [5:0]            int_chain_enable,
   output logic                  cpu_int_n,
   output logic                  cpu_nmi_n
);
   import bcg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode and helpers.

   bcg_io_if   io_bus ();
   bcg_byte_t  ctl_reg;
   logic       local_page;
   logic [1:0] local_sel;
   logic       id_hit;

   // Grant mask of the daisy chain: a device is enabled only while every
   // device ahead of it is quiet.
   function automatic logic [5:0] chain_grant(input logic [5:0] req);
      logic [5:0] g;
      logic       busy;
      g    = 6'h00;
      busy = 1'b0;
      for (int i = 0; i < 6; i++) begin
         g[i] = !busy;
         busy = busy | req[i];
      end
      return g;
   endfunction

   // Partial decode: address bit 2 is a don't-care, so ports alias at 04h..07h.
   assign local_page = ((io_addr & `BCG_LOCAL_PAGE_MASK) == `BCG_LOCAL_PAGE_VAL)
                       && !io_addr[3];
   assign local_sel  = io_addr[1:0];
   assign id_hit     = (io_addr & `BCG_ID_MASK) == `BCG_ID_VAL;

   ////////////////////////////////////////////////////////////////////////////////
   // Board control latch.

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg <= `BCG_CTL_RESET;
      end else if (io_wr && local_page && local_sel == `BCG_PORT_CONTROL) begin
         ctl_reg <= io_wdata;
      end
   end

   // The latch word is mirrored straight onto the pins; multiple drive selects
   // are software's problem and are not filtered here.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_select_one         <= 1'b0;
         drive_select_two         <= 1'b0;
         drive_select_three       <= 1'b0;
         drive_select_four        <= 1'b0;
         disk_side_select         <= 1'b0;
         density_select_n         <= 1'b0;
         floppy_clock_fast_select <= 1'b0;
         boot_rom_disable         <= 1'b0;
      end else if (io_wr && local_page && local_sel == `BCG_PORT_CONTROL) begin
         drive_select_one         <= io_wdata[0];
         drive_select_two         <= io_wdata[1];
         drive_select_three       <= io_wdata[2];
         drive_select_four        <= io_wdata[3];
         disk_side_select         <= io_wdata[`BCG_CTL_SIDE_BIT];
         density_select_n         <= io_wdata[`BCG_CTL_DENS_BIT];
         floppy_clock_fast_select <= io_wdata[`BCG_CTL_FAST_BIT];
         boot_rom_disable         <= io_wdata[`BCG_CTL_ROM_OFF_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Printer port.

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         printer_data <= `BCG_PRN_RESET;
      end else if (io_wr && local_page && local_sel == `BCG_PORT_PRN_DATA) begin
         printer_data <= io_wdata;
      end
   end

   // Strobe timing and polarity are left wholly to software.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         printer_strobe <= 1'b0;
      end else if (io_wr && local_page && local_sel == `BCG_PORT_STB_SET) begin
         printer_strobe <= 1'b1;
      end else if (io_wr && local_page && local_sel == `BCG_PORT_STB_CLR) begin
         printer_strobe <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Jumper input port.

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_rdata       <= 8'h00;
         io_rdata_valid <= 1'b0;
      end else begin
         io_rdata_valid <= io_rd && id_hit;
         io_rdata       <= (io_rd && id_hit) ? id_jumpers : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Memory cycle and baud helpers.

   assign io_bus.mem_req     = mem_req;
   assign io_bus.mem_a15     = mem_a15;
   assign io_bus.rom_disable = ctl_reg[`BCG_CTL_ROM_OFF_BIT];

   bcg_mem_wait u_mem_wait (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .io      (io_bus.memw)
   );

   bcg_baud_div #(
      .DIV (`BCG_ALT_BAUD_DIV)
   ) u_baud_div (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .io      (io_bus.baud)
   );

   assign mem_ready     = io_bus.mem_ready;
   assign rom_select    = io_bus.rom_select;
   assign ram_select    = io_bus.ram_select;
   assign alt_baud_tick = io_bus.alt_tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial controller side lines.

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         baud_fast_select       <= 1'b0;
         serial_a_handshake_out <= 1'b0;
         serial_b_handshake_out <= 1'b0;
         serial_a_clear_in      <= 1'b0;
         serial_b_clear_in      <= 1'b0;
      end else begin
         baud_fast_select       <= serial_a_terminal_ready_out;
         serial_a_handshake_out <= serial_a_request_out;
         serial_b_handshake_out <= serial_b_request_out;
         serial_a_clear_in      <= serial_a_handshake_in;
         serial_b_clear_in      <= serial_b_handshake_in;
      end
   end

   // The status lines are passed on as levels; the controller itself latches
   // changes, so no edge capture is kept here.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_b_ring_in    <= 1'b0;
         serial_b_carrier_in <= 1'b0;
         serial_a_carrier_in <= 1'b0;
         serial_a_ring_in    <= 1'b0;
      end else begin
         serial_b_ring_in    <= printer_busy;
         serial_b_carrier_in <= floppy_ready;
         serial_a_carrier_in <= jumper_aux_irq_en & aux_carrier_src;
         serial_a_ring_in    <= jumper_aux_irq_en & aux_ring_src;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt routing and priority chain.

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_trigger_2 <= 1'b0;
         timer_trigger_3 <= 1'b0;
      end else begin
         timer_trigger_2 <= jumper_ctc2_floppy ? floppy_irq : timer_clk_src_2;
         timer_trigger_3 <= jumper_ctc3_scsi ? scsi_irq : timer_clk_src_3;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_chain_enable <= 6'h3f;
         cpu_int_n        <= 1'b1;
         cpu_nmi_n        <= 1'b1;
      end else begin
         int_chain_enable <= chain_grant(int_req);
         cpu_int_n        <= !(|int_req);
         cpu_nmi_n        <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence s_ctl_write;
      io_wr && local_page && local_sel == `BCG_PORT_CONTROL;
   endsequence
   property p_ctl_update;
      bcg_byte_t d;
      @(posedge sys_clk) disable iff (!rst_n)
      (s_ctl_write, d = io_wdata) |=>
         {floppy_clock_fast_select, boot_rom_disable, density_select_n, disk_side_select,
          drive_select_four, drive_select_three, drive_select_two, drive_select_one} == d;
   endproperty
   a_ctl_update: assert property (p_ctl_update) else $error("control outputs not loaded");

   property p_ctl_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      !(io_wr && local_page && local_sel == `BCG_PORT_CONTROL) |=> $stable(ctl_reg);
   endproperty
   a_ctl_hold: assert property (p_ctl_hold) else $error("control latch changed");

   property p_rom_follows_bit6;
      @(posedge sys_clk) disable iff (!rst_n)
      ##1 boot_rom_disable == ctl_reg[`BCG_CTL_ROM_OFF_BIT];
   endproperty
   a_rom_follows_bit6: assert property (p_rom_follows_bit6) else $error("rom enable mismatch");

   property p_strobe_set;
      @(posedge sys_clk) disable iff (!rst_n)
      (io_wr && local_page && local_sel == `BCG_PORT_STB_SET) |=> printer_strobe;
   endproperty
   a_strobe_set: assert property (p_strobe_set) else $error("strobe not set");

   property p_strobe_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      !(io_wr && local_page && local_sel inside {`BCG_PORT_STB_SET, `BCG_PORT_STB_CLR})
         |=> $stable(printer_strobe);
   endproperty
   a_strobe_hold: assert property (p_strobe_hold) else $error("strobe moved");

   property p_strobe_clr;
      @(posedge sys_clk) disable iff (!rst_n)
      (io_wr && local_page && local_sel == `BCG_PORT_STB_CLR) |=> !printer_strobe;
   endproperty
   a_strobe_clr: assert property (p_strobe_clr) else $error("strobe not cleared");

   property p_prn_data;
      @(posedge sys_clk) disable iff (!rst_n)
      (io_wr && local_page && local_sel == `BCG_PORT_PRN_DATA) |=>
         printer_data == $past(io_wdata);
   endproperty
   a_prn_data: assert property (p_prn_data) else $error("printer data wrong");

   property p_id_read;
      @(posedge sys_clk) disable iff (!rst_n)
      (io_rd && id_hit) |=> io_rdata_valid && io_rdata == $past(id_jumpers);
   endproperty
   a_id_read: assert property (p_id_read) else $error("jumper read wrong");

   property p_chain_order;
      @(posedge sys_clk) disable iff (!rst_n)
      int_req[0] |=> int_chain_enable[0] && int_chain_enable[5:1] == 5'h00;
   endproperty
   a_chain_order: assert property (p_chain_order) else $error("daisy chain order wrong");

   property p_nmi_idle;
      @(posedge sys_clk) disable iff (!rst_n)
      1'b1 |-> cpu_nmi_n;
   endproperty
   a_nmi_idle: assert property (p_nmi_idle) else $error("nmi driven");

   property p_baud_follow;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(serial_a_terminal_ready_out) |=> baud_fast_select;
   endproperty
   a_baud_follow: assert property (p_baud_follow) else $error("baud select lag");
endmodule

`default_nettype wire

// ### common/bcg_defs.svh
// Purpose: Constants for the board control glue block.
// Assumes: Included by bare name from the package and the design files.
// Notes:   Definitions only.
`ifndef BCG_DEFS_SVH
`define BCG_DEFS_SVH

// Port decode: 0000_0x00 .. 0000_0x11 and the jumper port 0010_1xx1.
`define BCG_LOCAL_PAGE_MASK  8'hf8
`define BCG_LOCAL_PAGE_VAL   8'h00
`define BCG_LOCAL_SEL_MASK   8'h03
`define BCG_PORT_CONTROL     2'h0
`define BCG_PORT_PRN_DATA    2'h1
`define BCG_PORT_STB_SET     2'h2
`define BCG_PORT_STB_CLR     2'h3
`define BCG_ID_MASK          8'hf9
`define BCG_ID_VAL           8'h29

// Control latch fields and reset value.
`define BCG_CTL_FAST_BIT     7
`define BCG_CTL_ROM_OFF_BIT  6
`define BCG_CTL_DENS_BIT     5
`define BCG_CTL_SIDE_BIT     4
`define BCG_CTL_RESET        8'h00
`define BCG_PRN_RESET        8'h00

// Alternate baud divider: master clock over this ratio.
`define BCG_MASTER_CLK_HZ    16000000
`define BCG_ALT_BAUD_DIV     104
`define BCG_CPU_CLK_HZ       4000000
`define BCG_ROM_WAIT_STATES  1

`endif

// ### common/bcg_pkg.sv
// Purpose: Types shared by the board control glue modules.
// Assumes: bcg_defs.svh on the include path.
// Notes:   Constants live in the header; this holds types only.
`include "bcg_defs.svh"

package bcg_pkg;
   typedef logic [7:0] bcg_byte_t;
   typedef enum logic [1:0] {
      BCG_PRI_NONE,
      BCG_PRI_TIMER,
      BCG_PRI_SERIAL
   } bcg_pri_class_t;
   typedef enum {
      BCG_MEM_IDLE,
      BCG_MEM_WAIT
   } bcg_mem_state_t;
endpackage

// ### common/bcg_io_if.sv
// Purpose: Carrier between the glue top and its helper modules.
// Assumes: One clock domain.
// Notes:   Memory cycle handshake and the alternate baud tick.
`timescale 1ns/1ps
`default_nettype none

interface bcg_io_if;
   logic mem_req;
   logic mem_a15;
   logic rom_disable;
   logic mem_ready;
   logic rom_select;
   logic ram_select;
   logic alt_tick;

   modport top (output mem_req, output mem_a15, output rom_disable,
                input mem_ready, input rom_select, input ram_select, input alt_tick);
   modport memw (input mem_req, input mem_a15, input rom_disable,
                 output mem_ready, output rom_select, output ram_select);
   modport baud (output alt_tick);
endinterface

`default_nettype wire

// ### core/bcg_baud_div.sv
// Purpose: Alternate baud rate divider for serial channel A.
// Assumes: sys_clk stands for the master oscillator of the board.
// Notes:   Emits a one-cycle enable every DIV clocks.
`timescale 1ns/1ps
`default_nettype none
`include "bcg_defs.svh"

module bcg_baud_div #(
   parameter int DIV = `BCG_ALT_BAUD_DIV
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   bcg_io_if.baud    io
);
   import bcg_pkg::*;

   logic [7:0] cnt_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 8'h00;
      end else if (cnt_reg == 8'(DIV - 1)) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         io.alt_tick <= 1'b0;
      end else begin
         io.alt_tick <= (cnt_reg == 8'(DIV - 1));
      end
   end

   property p_alt_period;
      @(posedge sys_clk) disable iff (!rst_n)
      io.alt_tick |=> !io.alt_tick [*8] ##(DIV - 8) io.alt_tick;
   endproperty
   a_alt_period: assert property (p_alt_period) else $error("alt baud period wrong");
endmodule

`default_nettype wire

// ### core/bcg_mem_wait.sv
// Purpose: Boot ROM / RAM select and wait-state insertion.
// Assumes: One request pulse per memory cycle; requests during a wait are ignored.
// Notes:   RAM answers after one clock, ROM after two (one wait state).
`timescale 1ns/1ps
`default_nettype none

module bcg_mem_wait (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   bcg_io_if.memw    io
);
   import bcg_pkg::*;

   bcg_mem_state_t state_reg;
   logic           rom_hit;

   assign rom_hit = !io.mem_a15 && !io.rom_disable;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= BCG_MEM_IDLE;
         io.mem_ready  <= 1'b0;
         io.rom_select <= 1'b0;
         io.ram_select <= 1'b0;
      end else begin
         io.mem_ready <= 1'b0;
         case (state_reg)
            BCG_MEM_IDLE: begin
               if (io.mem_req) begin
                  io.rom_select <= rom_hit;
                  io.ram_select <= !rom_hit;
                  if (rom_hit) begin
                     state_reg <= BCG_MEM_WAIT;
                  end else begin
                     io.mem_ready <= 1'b1;
                  end
               end
            end
            BCG_MEM_WAIT: begin
               io.mem_ready <= 1'b1;
               state_reg    <= BCG_MEM_IDLE;
            end
            default: state_reg <= BCG_MEM_IDLE;
         endcase
      end
   end

   sequence s_rom_req;
      io.mem_req && state_reg == BCG_MEM_IDLE && rom_hit;
   endsequence
   sequence s_one_wait;
      !io.mem_ready ##1 io.mem_ready;
   endsequence
   property p_rom_wait;
      @(posedge sys_clk) disable iff (!rst_n)
      s_rom_req |=> s_one_wait;
   endproperty
   a_rom_wait: assert property (p_rom_wait) else $error("ROM cycle wait wrong");
   property p_ram_nowait;
      @(posedge sys_clk) disable iff (!rst_n)
      (io.mem_req && state_reg == BCG_MEM_IDLE && !rom_hit) |=> io.mem_ready && io.ram_select;
   endproperty
   a_ram_nowait: assert property (p_ram_nowait) else $error("RAM cycle waited");
endmodule

`default_nettype wire

// ### bench/bcg_host_model.sv
// Purpose: Host processor model driving the glue I/O and memory strobes.
// Assumes: Every request starts 10 ns after a rising edge of sys_clk.
// Notes:   Released address and data show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none

module bcg_host_model (
   input  wire logic               sys_clk,
   output var  bcg_pkg::bcg_byte_t io_addr,
   output var  bcg_pkg::bcg_byte_t io_wdata,
   output logic                    io_wr,
   output logic                    io_rd,
   output logic                    mem_req,
   output logic                    mem_a15,
   input  wire bcg_pkg::bcg_byte_t io_rdata,
   input  wire logic               io_rdata_valid,
   input  wire logic               mem_ready,
   input  wire logic               rom_select
);
   import bcg_pkg::*;

   initial begin
      {io_addr, io_wdata, io_wr, io_rd, mem_req, mem_a15} = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic io_write(input bcg_byte_t a, input bcg_byte_t d);
      {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
      @(posedge sys_clk);
      #10;
      {io_addr, io_wdata, io_wr} = {~a, ~d, 1'b0};
      @(posedge sys_clk);
      #10;
   endtask

   // Read data is taken in the cycle after the strobe, where it stands.
   task automatic io_read(input bcg_byte_t a, output logic v, output bcg_byte_t d);
      {io_addr, io_rd} = {a, 1'b1};
      @(posedge sys_clk);
      #10;
      {v, d} = {io_rdata_valid, io_rdata};
      {io_addr, io_rd} = {~a, 1'b0};
      @(posedge sys_clk);
      #10;
   endtask

   // The wait loop is bounded so a missing ready cannot hang the host.
   task automatic mem_cycle(input logic a15, output int waits, output logic rom);
      {mem_req, mem_a15} = {1'b1, a15};
      @(posedge sys_clk);
      #10;
      {mem_req, mem_a15} = {1'b0, ~a15};
      rom = rom_select;
      waits = 0;
      while (mem_ready !== 1'b1 && waits < 8) begin
         @(posedge sys_clk);
         #10;
         waits++;
      end
   endtask
endmodule

`default_nettype wire

// ### bench/testbench.sv
// Purpose: Self-checking bench for the board control glue top.
// Assumes: Inputs change 10 ns after the rising edge of sys_clk.
// Notes:   Each test prints one line when it ends.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e, m) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %0t %s", $time, m); end end

module testbench;
   import bcg_pkg::*;

   logic      sys_clk = 1'b0;
   logic      rst_n = 1'b0;
   bcg_byte_t io_addr, io_wdata, io_rdata, printer_data, id_jumpers;
   logic      io_wr, io_rd, io_rdata_valid, mem_req, mem_a15, mem_ready;
   logic      rom_select, ram_select, printer_strobe, alt_baud_tick;
   logic      drive_select_one, drive_select_two, drive_select_three, drive_select_four;
   logic      disk_side_select, density_select_n, floppy_clock_fast_select, boot_rom_disable;
   logic      serial_a_terminal_ready_out, baud_fast_select, serial_a_request_out;
   logic      serial_b_request_out, serial_a_handshake_out, serial_b_handshake_out;
   logic      serial_a_handshake_in, serial_b_handshake_in, serial_a_clear_in;
   logic      serial_b_clear_in, printer_busy, serial_b_ring_in, floppy_ready;
   logic      serial_b_carrier_in, aux_carrier_src, aux_ring_src, jumper_aux_irq_en;
   logic      serial_a_carrier_in, serial_a_ring_in, jumper_ctc2_floppy, jumper_ctc3_scsi;
   logic      timer_clk_src_2, timer_clk_src_3, floppy_irq, scsi_irq;
   logic      timer_trigger_2, timer_trigger_3, cpu_int_n, cpu_nmi_n;
   logic [5:0] int_req, int_chain_enable;
   logic [7:0] ctl;
   logic [9:0] side_in;
   logic [5:0] trig_in;
   int        mismatches = 0;
   int        checked = 0;
   int        cycles = 0;

   assign ctl = {floppy_clock_fast_select, boot_rom_disable, density_select_n, disk_side_select,
                 drive_select_four, drive_select_three, drive_select_two, drive_select_one};
   assign {serial_a_terminal_ready_out, serial_a_request_out, serial_b_request_out,
           serial_a_handshake_in, serial_b_handshake_in, printer_busy, floppy_ready,
           aux_carrier_src, aux_ring_src, jumper_aux_irq_en} = side_in;
   assign {jumper_ctc2_floppy, jumper_ctc3_scsi, timer_clk_src_2, timer_clk_src_3,
           floppy_irq, scsi_irq} = trig_in;

   bcg_top        dut_u  (.*);
   bcg_host_model host_u (.*);

   always #50 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // The ceiling is several times the length of the whole sequence.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         close_out();
      end
   end

   task automatic step;
      @(posedge sys_clk);
      #10;
   endtask

   function automatic logic [5:0] chain_exp(input logic [5:0] r);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 6; i++) begin
         chain_exp[i] = !seen;
         seen = seen | r[i];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic      v;
      bcg_byte_t d;
      int        w;
      logic      rom;
      {side_in, trig_in, int_req, id_jumpers} = '0;
      repeat (6) @(posedge sys_clk);
      #10;
      rst_n = 1'b1;
      `CHECK({ctl, printer_data, printer_strobe}, 17'h0, "reset outputs")
      `CHECK({int_chain_enable, cpu_int_n, cpu_nmi_n}, 8'hff, "reset chain")
      for (int i = 0; i < 8; i++) begin
         host_u.io_write({5'h0, i[0], 2'h0}, 8'h01 << i);
         `CHECK(ctl, 8'h01 << i, "control bit")
      end
      host_u.io_write(8'h08, 8'hff);
      `CHECK(ctl, 8'h80, "unmapped write")
      $display("test control done");
      host_u.io_write(8'h00, 8'h00);
      host_u.mem_cycle(1'b0, w, rom);
      `CHECK({w == 1, rom, ram_select}, 3'b110, "rom cycle")
      host_u.mem_cycle(1'b1, w, rom);
      `CHECK({w == 0, rom, ram_select}, 3'b101, "ram cycle")
      host_u.io_write(8'h00, 8'h40);
      host_u.mem_cycle(1'b0, w, rom);
      `CHECK({w == 0, rom, ram_select}, 3'b101, "rom hidden")
      $display("test memory done");
      host_u.io_write(8'h01, 8'ha5);
      `CHECK(printer_data, 8'ha5, "printer data")
      host_u.io_write(8'h02, 8'h00);
      `CHECK({printer_strobe, printer_data}, 9'h1a5, "strobe set")
      host_u.io_write(8'h03, 8'hff);
      `CHECK({printer_strobe, printer_data}, 9'h0a5, "strobe clear")
      $display("test printer done");
      id_jumpers = 8'h5c;
      host_u.io_read(8'h29, v, d);
      `CHECK({v, d}, 9'h15c, "id read")
      id_jumpers = 8'ha3;
      host_u.io_read(8'h2f, v, d);
      `CHECK({v, d}, 9'h1a3, "id alias read")
      host_u.io_read(8'h28, v, d);
      `CHECK({v, d}, 9'h000, "other read")
      $display("test id port done");
      for (int k = 0; k < 4; k++) begin
         side_in = (k == 0) ? 10'h3ff : (k == 1) ? 10'h2aa : (k == 2) ? 10'h155 : 10'h006;
         step();
         `CHECK({baud_fast_select, serial_a_handshake_out, serial_b_handshake_out,
                 serial_a_clear_in, serial_b_clear_in, serial_b_ring_in, serial_b_carrier_in,
                 serial_a_carrier_in, serial_a_ring_in},
                {side_in[9:3], side_in[2:1] & {2{side_in[0]}}}, "side lines")
      end
      for (int q = 0; q < 64; q++) begin
         trig_in = q[5:0];
         step();
         `CHECK({timer_trigger_2, timer_trigger_3}, {trig_in[5] ? trig_in[1] : trig_in[3],
                trig_in[4] ? trig_in[0] : trig_in[2]}, "trigger route")
      end
      for (int r = 0; r < 64; r++) begin
         int_req = r[5:0];
         step();
         `CHECK({int_chain_enable, cpu_int_n, cpu_nmi_n},
                {chain_exp(int_req), ~|int_req, 1'b1}, "daisy chain")
      end
      $display("test side lines done");
      w = 0;
      while (alt_baud_tick !== 1'b1 && w < 200) begin
         step();
         w++;
      end
      w = 0;
      do begin
         step();
         w++;
      end while (alt_baud_tick !== 1'b1 && w < 200);
      `CHECK(w == 104, 1'b1, "baud period")
      host_u.io_write(8'h00, 8'h41);
      rst_n = 1'b0;
      #10;
      `CHECK(ctl, 8'h00, "mid-run reset")
      step();
      rst_n = 1'b1;
      step();
      `CHECK({ctl, printer_strobe, alt_baud_tick}, 10'h000, "after reset")
      $display("test baud and reset done");
      close_out();
   end
endmodule

`default_nettype wire
